// *** logic/iep_regs.sv ***
// iep_regs: fourth enable register and five priority registers,
// apb slave, per-source enable/priority outputs to the arbiter
// assumes apb master per the usual two-phase protocol, one clock
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module iep_regs
   import iep_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [NUM_SRC-1:0]  src_req,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     irq,
   output logic                     crc_irq_enable,
   output logic                     serial2_error_irq_enable,
   output logic                     serial1_error_irq_enable,
   output logic      [3*NUM_SRC-1:0] src_prio,
   output logic      [NUM_SRC-1:0]  src_active,
   output logic      [NUM_SRC-1:0]  src_gated_req
);
   logic [15:0] enable4;
   logic [15:0] prio_val [5];
   logic        busy;
   logic [NUM_EV-1:0] stat;
   logic [NUM_EV-1:0] msk;
   logic        irq_int;

   // field extraction used for sources 0 to 16; sources 17 to 19 take RST_PRIO
   function automatic logic [2:0] fld(input logic [15:0] r, input int p);
      fld = r[p +: 3];
   endfunction : fld

   // bus decode; answer one cycle after setup so pready is registered
   iep_apb_req_type req;
   assign req = '{sel: psel, enable: penable, write: pwrite,
                  addr: paddr, wdata: pwdata};
   wire logic acc      = req.sel && req.enable && !busy;
   wire logic hit_en4  = req.addr == OFS_ENABLE4;
   wire logic hit_p0   = req.addr == OFS_PRIO0;
   wire logic hit_p1   = req.addr == OFS_PRIO1;
   wire logic hit_p2   = req.addr == OFS_PRIO2;
   wire logic hit_p3   = req.addr == OFS_PRIO3;
   wire logic hit_p4   = req.addr == OFS_PRIO4;
   wire logic hit_st   = req.addr == OFS_IRQ_STAT;
   wire logic hit_mk   = req.addr == OFS_IRQ_MASK;
   wire logic hit_act  = req.addr == OFS_ENABLED;
   wire logic mapped   = hit_en4 | hit_p0 | hit_p1 | hit_p2 | hit_p3 |
                         hit_p4 | hit_st | hit_mk | hit_act;
   wire logic wr_ok    = acc && req.write && mapped;
   wire logic [4:0] wr_prio = {hit_p4, hit_p3, hit_p2, hit_p1, hit_p0}
                            & {5{wr_ok}};
   wire logic [15:0] next_enable4 = req.wdata[15:0] & MASK_ENABLE4;

   // write masks per priority register
   localparam logic [15:0] PMASK [5] = '{MASK_PRIO4F, MASK_PRIO1,
                                         MASK_PRIO4F, MASK_PRIO3,
                                         MASK_PRIO4F};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_prio
         iep_prio_reg #(.WMASK(PMASK[gi])) u_prio (
            .core_clk (core_clk),
            .rstn     (rstn),
            .wr       (wr_prio[gi]),
            .wdata    (req.wdata[15:0]),
            .value    (prio_val[gi])
         );
      end
   endgenerate

   // source order: prio0 hi..lo, prio1, prio2, prio3 (two), prio4
   iep_src_type src [NUM_SRC];
   assign src[0]  = '{prio: fld(prio_val[0], POS_HI), en: 1'b1};
   assign src[1]  = '{prio: fld(prio_val[0], POS_MH), en: 1'b1};
   assign src[2]  = '{prio: fld(prio_val[0], POS_ML), en: 1'b1};
   assign src[3]  = '{prio: fld(prio_val[0], POS_LO), en: 1'b1};
   assign src[4]  = '{prio: fld(prio_val[1], POS_HI), en: 1'b1};
   assign src[5]  = '{prio: fld(prio_val[1], POS_MH), en: 1'b1};
   assign src[6]  = '{prio: fld(prio_val[1], POS_ML), en: 1'b1};
   assign src[7]  = '{prio: fld(prio_val[2], POS_HI), en: 1'b1};
   assign src[8]  = '{prio: fld(prio_val[2], POS_MH), en: 1'b1};
   assign src[9]  = '{prio: fld(prio_val[2], POS_ML), en: 1'b1};
   assign src[10] = '{prio: fld(prio_val[2], POS_LO), en: 1'b1};
   assign src[11] = '{prio: fld(prio_val[3], POS_ML), en: 1'b1};
   assign src[12] = '{prio: fld(prio_val[3], POS_LO), en: 1'b1};
   assign src[13] = '{prio: fld(prio_val[4], POS_HI), en: 1'b1};
   assign src[14] = '{prio: fld(prio_val[4], POS_MH), en: 1'b1};
   assign src[15] = '{prio: fld(prio_val[4], POS_ML), en: 1'b1};
   assign src[16] = '{prio: fld(prio_val[4], POS_LO), en: 1'b1};
   // enables of this register; no priority field lives in this slice
   assign src[17] = '{prio: RST_PRIO, en: enable4[BIT_CRC_EN]};
   assign src[18] = '{prio: RST_PRIO, en: enable4[BIT_SER2_EN]};
   assign src[19] = '{prio: RST_PRIO, en: enable4[BIT_SER1_EN]};

   logic [3*NUM_SRC-1:0] next_src_prio;
   logic [NUM_SRC-1:0]   next_active;
   logic [NUM_SRC-1:0]   next_gated;
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         next_src_prio[3*i +: 3] = src[i].prio;
         // zero priority takes a source out of arbitration
         next_active[i] = src[i].en && (src[i].prio != PRIO_OFF);
         next_gated[i]  = src_req[i] && next_active[i];
      end
   end

   logic [31:0] rd_mux;
   assign rd_mux = hit_en4 ? {16'h0000, enable4} :
                   hit_p0  ? {16'h0000, prio_val[0]} :
                   hit_p1  ? {16'h0000, prio_val[1]} :
                   hit_p2  ? {16'h0000, prio_val[2]} :
                   hit_p3  ? {16'h0000, prio_val[3]} :
                   hit_p4  ? {16'h0000, prio_val[4]} :
                   hit_st  ? {30'h0, stat} :
                   hit_mk  ? {30'h0, msk} :
                   hit_act ? {12'h000, src_active} : 32'h0000_0000;

   wire logic [NUM_EV-1:0] ev = {acc && !mapped, wr_ok};
   wire logic [NUM_EV-1:0] clr = (wr_ok && hit_st) ?
                                 req.wdata[NUM_EV-1:0] : '0;

   iep_irq_stat u_irq (
      .core_clk (core_clk),
      .rstn     (rstn),
      .event_in (ev),
      .clear_in (clr),
      .mask_wr  (wr_ok && hit_mk),
      .mask_in  (req.wdata[NUM_EV-1:0]),
      .status   (stat),
      .mask     (msk),
      .irq      (irq_int)
   );

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         enable4 <= RST_ENABLE4;
      end else if (wr_ok && hit_en4) begin
         enable4 <= next_enable4;
      end
   end

   // pready raised in the first access cycle, registered
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         busy    <= 1'b0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         busy    <= acc;
         pready  <= req.sel && !req.enable;
         pslverr <= req.sel && !req.enable && !mapped;
         prdata  <= (req.sel && !req.enable && !req.write) ? rd_mux
                                                           : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irq                      <= 1'b0;
         crc_irq_enable           <= 1'b0;
         serial2_error_irq_enable <= 1'b0;
         serial1_error_irq_enable <= 1'b0;
         src_prio                 <= '0;
         src_active               <= '0;
         src_gated_req            <= '0;
      end else begin
         irq                      <= irq_int;
         crc_irq_enable           <= enable4[BIT_CRC_EN];
         serial2_error_irq_enable <= enable4[BIT_SER2_EN];
         serial1_error_irq_enable <= enable4[BIT_SER1_EN];
         src_prio                 <= next_src_prio;
         src_active               <= next_active;
         src_gated_req            <= next_gated;
      end
   end

   sequence s_write_en4;
      psel && penable && pready && pwrite && paddr == OFS_ENABLE4;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   sequence s_write_p0;
      s_access ##0 (pwrite && paddr == OFS_PRIO0);
   endsequence

   sequence s_read_en4;
      (psel && !penable && !pwrite && paddr == OFS_ENABLE4) ##1 s_access;
   endsequence

   sequence s_read_p3;
      (psel && !penable && !pwrite && paddr == OFS_PRIO3) ##1 s_access;
   endsequence

   a_en4_write: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_write_en4 |=> ##1 crc_irq_enable == $past(pwdata[3], 2))
      else $error("crc enable not written");

   a_ser2_write: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_write_en4 |=> ##1 serial2_error_irq_enable == $past(pwdata[2], 2))
      else $error("serial2 enable not written");

   a_ser1_write: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_write_en4 |=> ##1 serial1_error_irq_enable == $past(pwdata[1], 2))
      else $error("serial1 enable not written");

   a_en4_unimpl: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (enable4 & ~MASK_ENABLE4) == 16'h0000)
      else $error("enable4 unimplemented bit set");

   a_en4_read: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_read_en4 |-> (prdata & 32'hFFFF_FFF1) == 32'h0000_0000)
      else $error("enable4 empty bits read nonzero");

   a_prio3_read: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_read_p3 |-> (prdata & ~{16'h0000, MASK_PRIO3}) == 32'h0000_0000)
      else $error("prio3 empty bits read nonzero");

   a_prio0_write: assert property (
      @(posedge core_clk) disable iff (!rstn)
      s_write_p0 |=> prio_val[0] == ($past(pwdata[15:0]) & MASK_PRIO4F))
      else $error("prio0 write did not land");

   a_prio1_low_empty: assert property (
      @(posedge core_clk) disable iff (!rstn)
      prio_val[1][3:0] == 4'h0)
      else $error("prio1 low nibble set");

   a_prio3_high_empty: assert property (
      @(posedge core_clk) disable iff (!rstn)
      prio_val[3][15:7] == 9'h000 && !prio_val[3][3])
      else $error("prio3 empty bits set");

   a_gate_block: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !src_req[17] || !enable4[BIT_CRC_EN] |=> !src_gated_req[17])
      else $error("disabled source passed");

   a_gate_pass: assert property (
      @(posedge core_clk) disable iff (!rstn)
      src_req[0] && prio_val[0][14:12] != 3'b000 |=> src_gated_req[0])
      else $error("enabled source blocked");

   a_gated_active: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (src_gated_req & ~src_active) == {NUM_SRC{1'b0}})
      else $error("inactive source passed");

   a_ser1_block: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !serial1_error_irq_enable |-> !src_gated_req[19])
      else $error("serial1 error passed while disabled");

   a_prio_off: assert property (
      @(posedge core_clk) disable iff (!rstn)
      prio_val[3][6:4] == 3'b000 |=> !src_active[11])
      else $error("zero priority still active");

   a_off_inactive: assert property (
      @(posedge core_clk) disable iff (!rstn)
      src_prio[50:48] == PRIO_OFF |-> !src_active[16])
      else $error("off source shown active");

   a_en_reset: assert property (
      @(posedge core_clk)
      !rstn |=> ##1 !crc_irq_enable && !serial1_error_irq_enable)
      else $error("enable not cleared at reset");

   a_prio_map: assert property (
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> src_prio[2:0] == $past(prio_val[0][14:12]))
      else $error("timer one priority misplaced");

   a_map_ext0: assert property (
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> src_prio[11:9] == $past(prio_val[0][2:0]))
      else $error("ext zero priority misplaced");

   a_map_serial_rx: assert property (
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> src_prio[23:21] == $past(prio_val[2][14:12]))
      else $error("serial1 receive priority misplaced");

   a_map_serial_tx: assert property (
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> src_prio[38:36] == $past(prio_val[3][2:0]))
      else $error("serial1 transmit priority misplaced");

   a_map_pin_change: assert property (
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> src_prio[41:39] == $past(prio_val[4][14:12]))
      else $error("pin change priority misplaced");

   a_active_prio: assert property (
      @(posedge core_clk) disable iff (!rstn)
      src_active[13] |-> src_prio[41:39] != PRIO_OFF)
      else $error("active source with zero priority");

   a_crc_active: assert property (
      @(posedge core_clk) disable iff (!rstn)
      src_active[17] == crc_irq_enable)
      else $error("crc active differs from enable");

   a_slv_ready: assert property (
      @(posedge core_clk) disable iff (!rstn)
      psel && !penable |=> pready)
      else $error("pready late");

   a_err_unmapped: assert property (
      @(posedge core_clk) disable iff (!rstn)
      psel && !penable && !mapped |=> pslverr)
      else $error("unmapped access without error");
endmodule : iep_regs
`default_nettype wire

// *** logic/iep_pkg.sv ***
// iep_pkg: constants and carrier types for the enable/priority slice
// assumes a 32-bit apb slave with registers on aligned words
package iep_pkg;
   localparam logic [7:0]  OFS_ENABLE4   = 8'h00;
   localparam logic [7:0]  OFS_PRIO0     = 8'h04;
   localparam logic [7:0]  OFS_PRIO1     = 8'h08;
   localparam logic [7:0]  OFS_PRIO2     = 8'h0C;
   localparam logic [7:0]  OFS_PRIO3     = 8'h10;
   localparam logic [7:0]  OFS_PRIO4     = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h1C;
   localparam logic [7:0]  OFS_ENABLED   = 8'h20;

   // field positions (low bit of each field)
   localparam int BIT_CRC_EN   = 3;
   localparam int BIT_SER2_EN  = 2;
   localparam int BIT_SER1_EN  = 1;
   localparam int POS_HI       = 12;
   localparam int POS_MH       = 8;
   localparam int POS_ML       = 4;
   localparam int POS_LO       = 0;

   // writable masks per register
   localparam logic [15:0] MASK_ENABLE4 = 16'h000E;
   localparam logic [15:0] MASK_PRIO4F  = 16'h7777;
   localparam logic [15:0] MASK_PRIO1   = 16'h7770;
   localparam logic [15:0] MASK_PRIO3   = 16'h0077;

   localparam logic [15:0] RST_ENABLE4  = 16'h0000;
   localparam logic [2:0]  RST_PRIO     = 3'b100;
   localparam logic [2:0]  PRIO_OFF     = 3'b000;

   localparam int NUM_SRC   = 20;
   localparam int NUM_EV    = 2;
   localparam int EV_WRITE  = 0;
   localparam int EV_ERR    = 1;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } iep_apb_req_type;

   typedef struct packed {
      logic [2:0] prio;
      logic       en;
   } iep_src_type;
endpackage : iep_pkg

// *** logic/iep_prio_reg.sv ***
// iep_prio_reg: one 16-bit register of four 3-bit priority fields
// assumes write strobe is a single cycle, masked to implemented bits
`timescale 1ns/1ps
`default_nettype none
module iep_prio_reg
   import iep_pkg::*;
#(
   parameter logic [15:0] WMASK = 16'h7777
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        wr,
   input  wire logic [15:0] wdata,
   output var  logic [15:0] value
);
   // reset loads 100 in each implemented field
   wire logic [15:0] rst_val = WMASK & {4{1'b0, RST_PRIO}};
   wire logic [15:0] next_value = wdata & WMASK;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         value <= rst_val;
      end else if (wr) begin
         value <= next_value;
      end
   end

   a_prio_reset_val: assert property (
      @(posedge core_clk) !rstn |=> value == rst_val)
      else $error("priority reset value wrong");
   a_prio_unimpl_zero: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (value & ~WMASK) == 16'h0000)
      else $error("unimplemented priority bit set");
endmodule : iep_prio_reg
`default_nettype wire

// *** logic/iep_irq_stat.sv ***
// iep_irq_stat: sticky event bits, write-one-to-clear, mask, level irq
// assumes events are one-cycle pulses from the register slave
`timescale 1ns/1ps
`default_nettype none
module iep_irq_stat
   import iep_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic [NUM_EV-1:0] event_in,
   input  wire logic [NUM_EV-1:0] clear_in,
   input  wire logic              mask_wr,
   input  wire logic [NUM_EV-1:0] mask_in,
   output var  logic [NUM_EV-1:0] status,
   output var  logic [NUM_EV-1:0] mask,
   output var  logic              irq
);
   // set beats clear so an event in the clearing cycle survives
   wire logic [NUM_EV-1:0] next_status = (status & ~clear_in) | event_in;
   wire logic              next_irq    = |(next_status & mask);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         status <= '0;
         mask   <= '0;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         if (mask_wr) mask <= mask_in;
         irq    <= |(next_status & (mask_wr ? mask_in : mask));
      end
   end

   a_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
      irq == |(status & mask))
      else $error("irq does not follow status and mask");
   a_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
      event_in[0] |=> status[0])
      else $error("event lost against clear");
endmodule : iep_irq_stat
`default_nettype wire

// *** bench/iep_src_model.sv ***
// iep_src_model: behavioural interrupt sources on the far side
// assumes the bench sets the wanted request pattern on want
`timescale 1ns/1ps
`default_nettype none
module iep_src_model
   import iep_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire logic [NUM_SRC-1:0] want,
   output var  logic [NUM_SRC-1:0] src_req
);
   // levels change just after an edge, never mid-cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         src_req <= '0;
      end else begin
         src_req <= want;
      end
   end
endmodule : iep_src_model
`default_nettype wire

// *** bench/tb_iep_regs.sv ***
// tb_iep_regs: self-checking bench for the enable/priority slice
// assumes the apb slave answers within a few cycles, one clock
`timescale 1ns/1ps
`default_nettype none
module tb_iep_regs
   import iep_pkg::*;
;
   logic                 core_clk = 1'b0;
   logic                 rstn     = 1'b0;
   iep_apb_req_type      req      = '0;
   logic [NUM_SRC-1:0]   want     = '0;
   logic [NUM_SRC-1:0]   src_req;
   logic [31:0]          prdata;
   logic                 pready, pslverr, irq;
   logic                 crc_en, ser2_en, ser1_en;
   logic [3*NUM_SRC-1:0] src_prio;
   logic [NUM_SRC-1:0]   src_active, src_gated_req;
   int                   miscompares = 0;
   int                   cmp_count   = 0;
   logic [7:0]  ofs [6] = '{OFS_ENABLE4, OFS_PRIO0, OFS_PRIO1, OFS_PRIO2,
                            OFS_PRIO3, OFS_PRIO4};
   logic [15:0] msk [6] = '{MASK_ENABLE4, MASK_PRIO4F, MASK_PRIO1,
                            MASK_PRIO4F, MASK_PRIO3, MASK_PRIO4F};
   logic [15:0] pat [6] = '{16'h0000, 16'h7531, 16'h6420, 16'h1357,
                            16'h0062, 16'h2460};
   logic [2:0]  exp_p [20] = '{3'h7, 3'h5, 3'h3, 3'h1, 3'h6, 3'h4, 3'h2,
                               3'h1, 3'h3, 3'h5, 3'h7, 3'h6, 3'h2, 3'h2,
                               3'h4, 3'h6, 3'h0, 3'h4, 3'h4, 3'h4};

   always #5 core_clk = ~core_clk;

   iep_src_model u_iep_src_model (.core_clk(core_clk), .rstn(rstn),
      .want(want), .src_req(src_req));

   iep_regs u_iep_regs (.core_clk(core_clk), .rstn(rstn), .psel(req.sel),
      .penable(req.enable), .pwrite(req.write), .paddr(req.addr),
      .pwdata(req.wdata), .src_req(src_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .crc_irq_enable(crc_en), .serial2_error_irq_enable(ser2_en),
      .serial1_error_irq_enable(ser1_en), .src_prio(src_prio),
      .src_active(src_active), .src_gated_req(src_gated_req));

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // one transfer; an idle cycle follows so req never moves twice at once
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
      @(posedge core_clk);
      req.enable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) begin
         miscompares++;
         print_verdict();
      end
      req <= '0;
      @(posedge core_clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
   endtask : rdc

   // outputs follow a register write two edges after release
   // read at the edge, before it updates; bus moves stay edge-aligned
   task automatic settle;
      repeat (3) @(posedge core_clk);
   endtask : settle

   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         rdc(ofs[i], {16'h0000, (i == 0) ? RST_ENABLE4 :
             ({4{1'b0, RST_PRIO}} & msk[i])});
      end
      settle();
      chk(src_prio, {NUM_SRC{RST_PRIO}});
      chk(src_active, {3'b000, 17'h1_FFFF});
      chk({crc_en, ser2_en, ser1_en, irq}, 4'h0);
      $display("test reset values done");
   endtask : t_reset

   task automatic t_masks;
      for (int i = 0; i < 6; i++) begin
         wr(ofs[i], 32'hFFFF_FFFF);
         rdc(ofs[i], {16'h0000, msk[i]});
         wr(ofs[i], 32'h0000_0000);
         rdc(ofs[i], 32'h0000_0000);
      end
      $display("test write masks done");
   endtask : t_masks

   task automatic t_fields;
      logic [3*NUM_SRC-1:0] ep;
      logic [NUM_SRC-1:0]   ea;
      for (int i = 1; i < 6; i++) wr(ofs[i], {16'h0000, pat[i]});
      for (int i = 1; i < 6; i++) rdc(ofs[i], {16'h0000, pat[i]});
      for (int i = 0; i < NUM_SRC; i++) begin
         ep[3*i +: 3] = exp_p[i];
         ea[i] = (i < 17) && (exp_p[i] != 3'b000);
      end
      settle();
      chk(src_prio, ep);
      chk(src_active, ea);
      rdc(OFS_ENABLED, {12'h000, ea});
      $display("test priority fields done");
   endtask : t_fields

   task automatic t_enable;
      want <= '1;
      for (int b = 1; b < 4; b++) begin
         wr(OFS_ENABLE4, 32'h0000_0001 << b);
         settle();
         chk({crc_en, ser2_en, ser1_en}, 3'b001 << (b - 1));
         chk(src_gated_req, {3'b001 << (3 - b), 17'h0_FFFF});
      end
      want <= '0;
      settle();
      chk(src_gated_req, 20'h0_0000);
      $display("test enable gating done");
   endtask : t_enable

   task automatic t_irq;
      logic [31:0] r;
      logic        e;
      wr(OFS_IRQ_MASK, 32'h0000_0002);
      apb(1'b1, 8'hF8, 32'hFFFF_FFFF, r, e);
      chk(e, 1'b1);
      apb(1'b0, 8'hFC, 32'h0000_0000, r, e);
      chk({e, r}, {1'b1, 32'h0000_0000});
      settle();
      chk(irq, 1'b1);
      rdc(OFS_IRQ_STAT, 32'h0000_0003);
      // the clearing write is itself an accepted write, so bit 0 stays
      wr(OFS_IRQ_STAT, 32'h0000_0003);
      rdc(OFS_IRQ_STAT, 32'h0000_0001);
      settle();
      chk(irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      settle();
      chk(irq, 1'b1);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      settle();
      chk(irq, 1'b0);
      $display("test interrupt status done");
   endtask : t_irq

   initial begin
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_masks();
      t_fields();
      t_enable();
      t_irq();
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      print_verdict();
   end
endmodule : tb_iep_regs
`default_nettype wire
